/* File: hw/oss_pkg.sv */
// Purpose: Shared types and constants of the oscillator start-up sequencer
// Assumes: One core clock at 250 MHz; oscillator pins sampled on it
// Notes:   Sub-clock offset and wait units are overridable at the top level for simulation
package oss_pkg;

  // Core clock rate
  localparam int unsigned CORE_CLK_MHZ      = 250;

  // Fixed extra oscillator cycles after the programmed wait
  localparam int unsigned MAIN_EXTRA_CYC    = 16384;
  localparam int unsigned PLL_EXTRA_CYC     = 131072;
  localparam int unsigned SUB_EXTRA_CYC     = 0;

  // Sub-clock fixed offset, least figure in ms, rounded up to core cycles
  localparam int unsigned SUB_OFFSET_MIN_MS = 1800;
  localparam int unsigned SUB_OFFSET_CYC    =
    SUB_OFFSET_MIN_MS * 1000 * CORE_CLK_MHZ;

  // Oscillator cycles per step of a wait select field
  localparam int unsigned WAIT_UNIT_CYC     = 1;

  // Counter width, wide enough for the sub-clock offset
  localparam int unsigned CNT_W             = 32;
  localparam int unsigned WSEL_W            = 5;
  localparam int unsigned DIV_W             = 3;

  // Division ratio codes: two illegal with the main clock as source, then the reset code
  localparam logic [2:0]  DIV_BY_1          = 3'h0;
  localparam logic [2:0]  DIV_BY_2          = 3'h1;
  localparam logic [2:0]  DIV_RST           = 3'h2;

  // System clock sources
  typedef enum logic [2:0] {
    SRC_SLOW, SRC_FAST, SRC_MAIN, SRC_SUB, SRC_PLL
  } oss_src_type;

  // Sub-clock and RTC configuration patterns
  typedef enum logic [2:0] {
    PAT_A, PAT_B, PAT_C, PAT_D, PAT_E
  } oss_pattern_type;

  // Oscillator enable with its wait select field
  typedef struct packed {
    logic                osc_en;
    logic [WSEL_W-1:0]   wait_select;
  } oss_osc_ctrl_type;

  // PLL input divider and multiplier settings
  typedef struct packed {
    logic [1:0]          in_div;
    logic [5:0]          mul;
  } oss_pll_cfg_type;

  // Clock division ratios per internal clock
  typedef struct packed {
    logic [DIV_W-1:0]    core_system_clock;
    logic [DIV_W-1:0]    periph_bus_a_clock;
    logic [DIV_W-1:0]    periph_bus_b_clock;
    logic [DIV_W-1:0]    flash_if_clock;
    logic [DIV_W-1:0]    ie_bus_clock;
  } oss_div_type;

  // Stabilisation flags
  typedef struct packed {
    logic                main_ready;
    logic                pll_ready;
    logic                sub_ready;
  } oss_ready_type;

endpackage

/* File: hw/oss_wait_counter.sv */
// Purpose: One oscillation stabilisation wait counter
// Assumes: Oscillator arrives as a pin, slower than half the core clock
// Notes:   Optional fixed offset counted in core cycles before edges
`timescale 1ns/1ps
module oss_wait_counter #(
  parameter int unsigned EXTRA  = 16384,
  parameter int unsigned UNIT   = 1,
  parameter int unsigned OFFSET = 1
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      osc_pin,
  input  wire logic                      run,
  input  wire logic                      offset_en,
  input  wire logic [oss_pkg::WSEL_W-1:0] wait_select,
  output logic                           stable
);
  import oss_pkg::*;

  typedef enum {W_IDLE, W_OFFSET, W_COUNT, W_DONE} oss_wstate_type;

  logic                 sync1_r;     // First synchroniser stage only
  logic                 sync2_r;     // Safe sampled oscillator level
  logic                 prev_r;      // Previous level for edge finding
  oss_wstate_type       state_r;     // Wait phase
  oss_wstate_type       state_nxt;
  logic [CNT_W-1:0]     cnt_r;       // Cycles or edges counted so far
  logic [CNT_W-1:0]     cnt_nxt;
  logic                 stable_r;    // Clock may be passed on
  logic                 stable_nxt;
  logic                 osc_edge;    // Rising edge of the oscillator
  logic [CNT_W-1:0]     target;      // Edges due in the count phase

  assign osc_edge = sync2_r & ~prev_r;
  assign target   = CNT_W'(wait_select) * CNT_W'(UNIT) + CNT_W'(EXTRA);
  assign stable   = stable_r;

  // Next phase; dropping run restarts the whole wait
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    stable_nxt = 1'b0;
    case (state_r)
      W_IDLE: begin
        cnt_nxt = '0;
        if (run) begin
          state_nxt = (offset_en && OFFSET != 0) ? W_OFFSET : W_COUNT;
        end
      end
      W_OFFSET: begin
        // Fixed offset runs on the core clock, crystal may not toggle yet
        if (!run) begin
          state_nxt = W_IDLE;
        end else if (cnt_r >= CNT_W'(OFFSET) - CNT_W'(1)) begin
          state_nxt = W_COUNT;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + CNT_W'(1);
        end
      end
      W_COUNT: begin
        if (!run) begin
          state_nxt = W_IDLE;
        end else if (cnt_r >= target) begin
          state_nxt  = W_DONE;
          stable_nxt = 1'b1;
        end else if (osc_edge) begin
          cnt_nxt = cnt_r + CNT_W'(1);
        end
      end
      W_DONE: begin
        stable_nxt = run;
        if (!run) begin
          state_nxt = W_IDLE;
        end
      end
      default: begin
        state_nxt = W_IDLE;
      end
    endcase
  end

  // Registers, including the pin synchroniser
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r  <= 1'b0;
      sync2_r  <= 1'b0;
      prev_r   <= 1'b0;
      state_r  <= W_IDLE;
      cnt_r    <= '0;
      stable_r <= 1'b0;
    end else begin
      sync1_r  <= osc_pin;
      sync2_r  <= sync1_r;
      prev_r   <= sync2_r;
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      stable_r <= stable_nxt;
    end
  end

endmodule // oss_wait_counter

/* File: hw/oss_top.sv */
// Purpose: Oscillator start-up sequencer with clock source switch
// Assumes: Software drives the control ports on core_clk; power-on reset
// Notes:   Oscillator pins are counted, never used as clocks here
//
// Function
// - Main clock passes after select plus 16384
// - PLL passes after select plus 131072 cycles
// - Five sub-clock and RTC patterns supported
// - Sub-clock waits fixed offset plus select
// - 64-pin parts have no sub-clock offset
// - Fast oscillator may stop and power off
`timescale 1ns/1ps
module oss_top #(
  parameter int unsigned SUB_OFFSET = oss_pkg::SUB_OFFSET_CYC,
  parameter int unsigned MAIN_UNIT  = oss_pkg::WAIT_UNIT_CYC,
  parameter int unsigned PLL_UNIT   = oss_pkg::WAIT_UNIT_CYC,
  parameter int unsigned SUB_UNIT   = oss_pkg::WAIT_UNIT_CYC
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      main_osc_pin,
  input  wire logic                      pll_osc_pin,
  input  wire logic                      sub_osc_pin,
  input  wire logic                      pkg_64pin,
  input  wire oss_pkg::oss_osc_ctrl_type main_osc_wait_ctrl,
  input  wire oss_pkg::oss_osc_ctrl_type pll_wait_ctrl,
  input  wire oss_pkg::oss_osc_ctrl_type sub_osc_wait_ctrl,
  input  wire oss_pkg::oss_pll_cfg_type  pll_cfg,
  input  wire oss_pkg::oss_pattern_type  sub_pattern,
  input  wire oss_pkg::oss_div_type      div_cfg,
  input  wire logic                      src_switch_req,
  input  wire oss_pkg::oss_src_type      src_switch_sel,
  input  wire logic                      fast_osc_run_req,
  input  wire logic                      fast_osc_pwr_req,
  output oss_pkg::oss_ready_type         ready,
  output oss_pkg::oss_src_type           sys_clk_src,
  output logic                           switch_done,
  output logic                           switch_refused,
  output oss_pkg::oss_pll_cfg_type       pll_cfg_out,
  output oss_pkg::oss_div_type           div_out,
  output logic                           div_fault,
  output logic                           rtc_src_sub,
  output logic                           rtc_en,
  output logic                           sub_osc_en_out,
  output logic                           fast_osc_en_out,
  output logic                           fast_osc_pwr_out
);
  import oss_pkg::*;

  logic             main_ok;      // Main clock usable
  logic             pll_ok;       // PLL output usable
  logic             sub_ok;       // Sub-clock usable
  logic             pll_run;      // PLL wait may run
  logic             sub_run;      // Sub-clock wait may run
  logic             sub_used;     // Pattern uses the sub crystal
  logic             sub_sys_ok;   // Pattern lets sub be system clock

  oss_src_type      src_r;        // Current system clock source
  oss_src_type      src_nxt;
  logic             done_r;       // Switch taken, one cycle
  logic             done_nxt;
  logic             refused_r;    // Switch refused, one cycle
  logic             refused_nxt;
  logic             tgt_ok;       // Requested source may be taken

  oss_pll_cfg_type  pllc_r;       // Latched PLL settings
  oss_pll_cfg_type  pllc_nxt;
  oss_div_type      div_r;        // Applied division ratios
  oss_div_type      div_nxt;
  logic             fault_r;      // Illegal divider with main source
  logic             fault_nxt;
  logic             rtcs_r;       // RTC counts the sub-clock
  logic             rtcs_nxt;
  logic             rtce_r;       // RTC running
  logic             rtce_nxt;
  logic             suben_r;      // Sub crystal driver on
  logic             suben_nxt;
  logic             fen_r;        // Fast on-chip oscillator running
  logic             fen_nxt;
  logic             fpwr_r;       // Fast on-chip oscillator powered
  logic             fpwr_nxt;

  // Main oscillator wait: select field plus fixed extra edges
  oss_wait_counter #(
    .EXTRA       (MAIN_EXTRA_CYC),
    .UNIT        (MAIN_UNIT),
    .OFFSET      (0)
  ) u_main_wait (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .osc_pin     (main_osc_pin),
    .run         (main_osc_wait_ctrl.osc_en),
    .offset_en   (1'b0),
    .wait_select (main_osc_wait_ctrl.wait_select),
    .stable      (main_ok)
  );

  // PLL only starts counting once the main clock is stable
  assign pll_run = pll_wait_ctrl.osc_en & main_ok;

  oss_wait_counter #(
    .EXTRA       (PLL_EXTRA_CYC),
    .UNIT        (PLL_UNIT),
    .OFFSET      (0)
  ) u_pll_wait (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .osc_pin     (pll_osc_pin),
    .run         (pll_run),
    .offset_en   (1'b0),
    .wait_select (pll_wait_ctrl.wait_select),
    .stable      (pll_ok)
  );

  // Pattern decode for sub crystal, RTC source and sub as system clock
  assign sub_used   = (sub_pattern == PAT_C) || (sub_pattern == PAT_D) ||
                      (sub_pattern == PAT_E);
  assign sub_sys_ok = (sub_pattern == PAT_C) || (sub_pattern == PAT_E);
  assign sub_run    = sub_osc_wait_ctrl.osc_en & sub_used;

  // Offset is skipped on 64-pin parts
  oss_wait_counter #(
    .EXTRA       (SUB_EXTRA_CYC),
    .UNIT        (SUB_UNIT),
    .OFFSET      (SUB_OFFSET)
  ) u_sub_wait (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .osc_pin     (sub_osc_pin),
    .run         (sub_run),
    .offset_en   (~pkg_64pin),
    .wait_select (sub_osc_wait_ctrl.wait_select),
    .stable      (sub_ok)
  );

  // Is the requested source ready to carry the system clock
  always_comb begin
    case (src_switch_sel)
      SRC_SLOW: tgt_ok = 1'b1;
      SRC_FAST: tgt_ok = fen_r;
      SRC_MAIN: tgt_ok = main_ok;
      SRC_SUB:  tgt_ok = sub_ok & sub_sys_ok;
      SRC_PLL:  tgt_ok = pll_ok;
      default:  tgt_ok = 1'b0;
    endcase
  end

  // Source switch; refusing keeps the old clock, so no glitch
  always_comb begin
    src_nxt     = src_r;
    done_nxt    = 1'b0;
    refused_nxt = 1'b0;
    if (src_switch_req) begin
      if (tgt_ok) begin
        src_nxt  = src_switch_sel;
        done_nxt = 1'b1;
      end else begin
        refused_nxt = 1'b1;
      end
    end
  end

  // Settings that follow software, with the RTC and oscillator controls
  always_comb begin
    pllc_nxt  = pll_cfg;
    // PLL settings only taken while PLL is off; skipping leaves them idle
    if (pll_wait_ctrl.osc_en) begin
      pllc_nxt = pllc_r;
    end
    div_nxt   = div_cfg;
    // Divide-by-1 or 2 of core system or bus B clock with main as source is flagged, never hidden
    fault_nxt = (src_r == SRC_MAIN) &&
                ((div_cfg.core_system_clock == DIV_BY_1) ||
                 (div_cfg.core_system_clock == DIV_BY_2) ||
                 (div_cfg.periph_bus_b_clock == DIV_BY_1) ||
                 (div_cfg.periph_bus_b_clock == DIV_BY_2));
    rtcs_nxt  = sub_used;
    rtce_nxt  = (sub_pattern == PAT_B) || (sub_pattern == PAT_D) ||
                (sub_pattern == PAT_E);
    suben_nxt = sub_run;
    // Fast oscillator cannot stop from the second cycle that it carries the system clock
    fpwr_nxt  = fast_osc_pwr_req || (src_r == SRC_FAST);
    fen_nxt   = (fast_osc_run_req && fast_osc_pwr_req) ||
                (src_r == SRC_FAST);
  end

  // Register stage for all control state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_r     <= SRC_SLOW;
      done_r    <= 1'b0;
      refused_r <= 1'b0;
      pllc_r    <= '0;
      div_r     <= {5{DIV_RST}};
      fault_r   <= 1'b0;
      rtcs_r    <= 1'b0;
      rtce_r    <= 1'b0;
      suben_r   <= 1'b0;
      fen_r     <= 1'b0;
      fpwr_r    <= 1'b0;
    end else begin
      src_r     <= src_nxt;
      done_r    <= done_nxt;
      refused_r <= refused_nxt;
      pllc_r    <= pllc_nxt;
      div_r     <= div_nxt;
      fault_r   <= fault_nxt;
      rtcs_r    <= rtcs_nxt;
      rtce_r    <= rtce_nxt;
      suben_r   <= suben_nxt;
      fen_r     <= fen_nxt;
      fpwr_r    <= fpwr_nxt;
    end
  end

  // Outputs, each from a flip-flop
  assign ready.main_ready = main_ok;
  assign ready.pll_ready  = pll_ok;
  assign ready.sub_ready  = sub_ok;
  assign sys_clk_src      = src_r;
  assign switch_done      = done_r;
  assign switch_refused   = refused_r;
  assign pll_cfg_out      = pllc_r;
  assign div_out          = div_r;
  assign div_fault        = fault_r;
  assign rtc_src_sub      = rtcs_r;
  assign rtc_en           = rtce_r;
  assign sub_osc_en_out   = suben_r;
  assign fast_osc_en_out  = fen_r;
  assign fast_osc_pwr_out = fpwr_r;

endmodule // oss_top

/* File: dv/oss_monitor.sv */
// Purpose: Concurrent checks on the sequencer ports
// Assumes: One core_clk domain, rst_n async low
// Notes:   Saturating cycle counters stand in for the long waits
`timescale 1ns/1ps
module oss_monitor #(
  parameter int unsigned SUB_OFFSET = 20
) (
  input wire logic                      core_clk,
  input wire logic                      rst_n,
  input wire logic                      pkg_64pin,
  input wire oss_pkg::oss_osc_ctrl_type main_osc_wait_ctrl,
  input wire oss_pkg::oss_osc_ctrl_type sub_osc_wait_ctrl,
  input wire oss_pkg::oss_pattern_type  sub_pattern,
  input wire oss_pkg::oss_div_type      div_cfg,
  input wire logic                      src_switch_req,
  input wire oss_pkg::oss_src_type      src_switch_sel,
  input wire oss_pkg::oss_ready_type    ready,
  input wire oss_pkg::oss_src_type      sys_clk_src,
  input wire logic                      switch_done,
  input wire logic                      switch_refused,
  input wire logic                      div_fault,
  input wire logic                      rtc_src_sub,
  input wire logic                      fast_osc_en_out,
  input wire logic                      fast_osc_pwr_out
);
  import oss_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] main_cnt_r, main_cnt_nxt; // Cycles main wait has run
  logic [31:0] sub_cnt_r, sub_cnt_nxt;   // Cycles sub wait has run
  logic        sub_run;                  // Sub wait enabled
  // Counters clear when the wait stops unless saturated; at all ones they hold, so they never wrap
  always_comb begin
    sub_run      = sub_osc_wait_ctrl.osc_en &&
                   (sub_pattern inside {PAT_C, PAT_D, PAT_E});
    main_cnt_nxt = main_osc_wait_ctrl.osc_en ? main_cnt_r + 32'h1 : 32'h0;
    sub_cnt_nxt = sub_run ? sub_cnt_r + 32'h1 : 32'h0;
    if (&main_cnt_r) main_cnt_nxt = main_cnt_r;
    if (&sub_cnt_r) sub_cnt_nxt = sub_cnt_r;
  end
  // Register the counters
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_cnt_r <= 32'h0;
      sub_cnt_r  <= 32'h0;
    end else begin
      main_cnt_r <= main_cnt_nxt;
      sub_cnt_r  <= sub_cnt_nxt;
    end
  end
  // A request whose target is not usable yet
  sequence s_ask_unready;
    src_switch_req && ((src_switch_sel == SRC_MAIN && !ready.main_ready) ||
      (src_switch_sel == SRC_PLL && !ready.pll_ready) ||
      (src_switch_sel == SRC_FAST && !fast_osc_en_out) ||
      (src_switch_sel == SRC_SUB && !(sub_pattern inside {PAT_C, PAT_E})));
  endsequence
  // Refusal leaves the source where it was
  sequence s_refuse;
    switch_refused && !switch_done && $stable(sys_clk_src);
  endsequence
  // Every request gets exactly one answer pulse
  a_switch_answer: assert property (
    src_switch_req |=> switch_done != switch_refused)
    else $error("switch not answered");
  a_unready_refused: assert property (
    s_ask_unready |=> s_refuse)
    else $error("unready source taken");
  a_done_source: assert property (
    switch_done |-> $past(src_switch_req) &&
      sys_clk_src == $past(src_switch_sel))
    else $error("wrong source");
  a_pll_after_main: assert property (
    ready.pll_ready |-> $past(ready.main_ready))
    else $error("pll ready early");
  a_main_drop: assert property (
    !main_osc_wait_ctrl.osc_en |=> !ready.main_ready)
    else $error("main ready held");
  // Each counted edge costs at least one core cycle, so cycles bound it
  a_main_wait: assert property (
    $rose(ready.main_ready) |->
      main_cnt_r >= MAIN_EXTRA_CYC + main_osc_wait_ctrl.wait_select)
    else $error("main ready early");
  a_sub_offset: assert property (
    $rose(ready.sub_ready) && !pkg_64pin |->
      sub_cnt_r >= SUB_OFFSET + sub_osc_wait_ctrl.wait_select)
    else $error("sub offset short");
  a_div_flag: assert property (
    (sys_clk_src == SRC_MAIN && div_cfg.core_system_clock == DIV_BY_1) [*3]
    |-> div_fault)
    else $error("div fault missed");
  a_rtc_source: assert property (
    rtc_src_sub == ($past(sub_pattern) inside {PAT_C, PAT_D, PAT_E}))
    else $error("rtc source wrong");
  a_fast_kept: assert property (
    sys_clk_src == SRC_FAST && $past(sys_clk_src) == SRC_FAST |->
      fast_osc_en_out && fast_osc_pwr_out)
    else $error("fast osc dropped");
endmodule // oss_monitor
bind oss_top oss_monitor #(.SUB_OFFSET(SUB_OFFSET)) mon_u (.core_clk, .rst_n,
  .pkg_64pin, .main_osc_wait_ctrl, .sub_osc_wait_ctrl, .sub_pattern, .div_cfg,
  .src_switch_req, .src_switch_sel, .ready, .sys_clk_src, .switch_done,
  .switch_refused, .div_fault, .rtc_src_sub, .fast_osc_en_out,
  .fast_osc_pwr_out);

/* File: dv/oss_top_tb.sv */
// Purpose: Directed bench for the oscillator start-up sequencer
// Assumes: Inputs driven 1 ns after each rising edge of core_clk
// Notes:   The PLL wait is too long to finish here; only its refusal runs
`timescale 1ns/1ps
module oss_top_tb;
  import oss_pkg::*;
  localparam int unsigned SUB_OFF = 20;    // Short offset for simulation
  localparam int unsigned TMO     = 90000; // Main wait needs about 66k cycles
  logic core_clk = 1'h0, rst_n = 1'h0, pkg_64pin = 1'h0;
  logic [1:0] ph = 2'h0;                   // Pins run at a quarter of core_clk
  wire  main_osc_pin = ph[1], pll_osc_pin = ph[1], sub_osc_pin = ph[1];
  oss_osc_ctrl_type main_osc_wait_ctrl = 6'h00, pll_wait_ctrl = 6'h00;
  oss_osc_ctrl_type sub_osc_wait_ctrl = 6'h00;
  oss_pll_cfg_type  pll_cfg = 8'h00, pll_cfg_out;
  oss_pattern_type  sub_pattern = PAT_A;
  oss_div_type      div_cfg = {5{DIV_RST}}, div_out;
  logic src_switch_req = 1'h0, fast_osc_run_req = 1'h0, fast_osc_pwr_req = 1'h0;
  oss_src_type src_switch_sel = SRC_SLOW, sys_clk_src;
  oss_ready_type ready;
  logic switch_done, switch_refused, div_fault, rtc_src_sub, rtc_en;
  logic sub_osc_en_out, fast_osc_en_out, fast_osc_pwr_out, pin_q = 1'h0;
  int bad_count = 0, n_compared = 0, cyc = 0, edges = 0, n, p;
  oss_top #(.SUB_OFFSET(SUB_OFF)) dut_u (.core_clk, .rst_n, .main_osc_pin,
    .pll_osc_pin, .sub_osc_pin, .pkg_64pin, .main_osc_wait_ctrl,
    .pll_wait_ctrl, .sub_osc_wait_ctrl, .pll_cfg, .sub_pattern, .div_cfg,
    .src_switch_req, .src_switch_sel, .fast_osc_run_req, .fast_osc_pwr_req,
    .ready, .sys_clk_src, .switch_done, .switch_refused, .pll_cfg_out,
    .div_out, .div_fault, .rtc_src_sub, .rtc_en, .sub_osc_en_out,
    .fast_osc_en_out, .fast_osc_pwr_out);
  always #2 core_clk = ~core_clk;
  // Pin phase, timeout and main pin edge count while main wait runs
  always @(posedge core_clk) begin
    cyc++;
    if (main_osc_wait_ctrl.osc_en && main_osc_pin && !pin_q) edges++;
    pin_q = main_osc_pin;
    if (cyc == TMO) begin
      bad_count++;
      results();
    end
    #1 ph = ph + 2'h1;
  end
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // One switch request; the answer pulse is seen one edge later
  task automatic sw(input oss_src_type s, input logic ok,
                    input oss_src_type e);
    src_switch_sel = s;
    src_switch_req = 1'h1;
    tick(1);
    src_switch_req = 1'h0;
    chk(switch_done, ok);
    chk(switch_refused, !ok);
    chk(sys_clk_src, e);
    tick(1);
  endtask
  // Bounded wait for the ready bits in m
  task automatic wait_rdy(input logic [2:0] m, input int lim);
    for (n = 0; n < lim && (ready & m) != m; n++) tick(1);
    chk(ready & m, m);
  endtask
  initial begin
    tick(10);
    chk(div_out, {5{DIV_RST}});
    chk(sys_clk_src, SRC_SLOW);
    chk(ready, 3'h0);
    rst_n = 1'h1;
    tick(1);
    // Every sub-clock and RTC pattern
    sub_osc_wait_ctrl = 6'h22;
    for (p = 0; p < 5; p++) begin
      sub_pattern = oss_pattern_type'(p);
      tick(2);
      chk(rtc_src_sub, p >= 2);
      chk(rtc_en, p == 1 || p >= 3);
      chk(sub_osc_en_out, p >= 2);
    end
    sub_osc_wait_ctrl = 6'h00;
    tick(3);
    $display("Test patterns done");
    // Sub wait with and without offset, then source rules for the sub-clock
    for (p = 0; p < 2; p++) begin
      pkg_64pin = p[0];
      sub_pattern = PAT_D;
      sub_osc_wait_ctrl = 6'h22;
      wait_rdy(3'h1, 200);
      chk(p ? n < 20 : n > 22, 1'h1);
      sw(SRC_SUB, 1'h0, SRC_SLOW);
      sub_pattern = PAT_E;
      tick(1);
      sw(SRC_SUB, 1'h1, SRC_SUB);
      sw(SRC_SLOW, 1'h1, SRC_SLOW);
      sub_osc_wait_ctrl = 6'h00;
      tick(3);
      chk(ready.sub_ready, 1'h0);
    end
    $display("Test sub wait done");
    // Fast oscillator run, forced on while in use, then off
    sw(SRC_MAIN, 1'h0, SRC_SLOW);
    sw(SRC_PLL, 1'h0, SRC_SLOW);
    sw(SRC_FAST, 1'h0, SRC_SLOW);
    fast_osc_run_req = 1'h1;
    fast_osc_pwr_req = 1'h1;
    tick(2);
    sw(SRC_FAST, 1'h1, SRC_FAST);
    fast_osc_run_req = 1'h0;
    fast_osc_pwr_req = 1'h0;
    tick(2);
    chk({fast_osc_en_out, fast_osc_pwr_out}, 2'h3);
    sw(SRC_SLOW, 1'h1, SRC_SLOW);
    tick(2);
    chk({fast_osc_en_out, fast_osc_pwr_out}, 2'h0);
    $display("Test fast osc done");
    // PLL settings frozen while enabled; no wait before main is stable
    pll_cfg = 8'h4F;
    tick(2);
    chk(pll_cfg_out, 8'h4F);
    pll_wait_ctrl = 6'h2A;
    tick(1);
    pll_cfg = 8'h13;
    tick(2);
    chk(pll_cfg_out, 8'h4F);
    chk(ready.pll_ready, 1'h0);
    // Main wait of select 0Ch plus 16384 pin edges; select goes in first,
    // and enable lands two edges after a pin rise, so neither side counts it
    main_osc_wait_ctrl.wait_select = 5'h0C;
    while (cyc % 4 != 0) tick(1);
    main_osc_wait_ctrl.osc_en = 1'h1;
    edges = 0;
    wait_rdy(3'h4, 70000);
    chk(edges >= 16396 && edges <= 16398, 1'h1);
    sw(SRC_MAIN, 1'h1, SRC_MAIN);
    div_cfg.core_system_clock = DIV_BY_1;
    tick(3);
    chk(div_fault, 1'h1);
    chk(div_out.core_system_clock, DIV_BY_1);
    div_cfg = {5{3'h3}};
    tick(3);
    chk(div_fault, 1'h0);
    div_cfg.periph_bus_b_clock = DIV_BY_2;
    tick(3);
    chk(div_fault, 1'h1);
    sw(SRC_PLL, 1'h0, SRC_MAIN);
    sw(SRC_SLOW, 1'h1, SRC_SLOW);
    main_osc_wait_ctrl = 6'h00;
    tick(3);
    chk(ready, 3'h0);
    $display("Test main wait done");
    results();
  end
endmodule // oss_top_tb
